// ===== abw_pkg.sv
package abw_pkg;
   // Measurement clock dividers: eight times the generator base divider.
   localparam int unsigned ABD_DIV_SLOW = 512;
   localparam int unsigned ABD_DIV_MID = 128;
   localparam int unsigned ABD_DIV_FAST = 32;
   localparam int unsigned PRESCALE_W = 9;
   localparam logic [PRESCALE_W-1:0] PRESCALE_SLOW_LAST = PRESCALE_W'(ABD_DIV_SLOW - 1);
   localparam logic [PRESCALE_W-1:0] PRESCALE_MID_LAST = PRESCALE_W'(ABD_DIV_MID - 1);
   localparam logic [PRESCALE_W-1:0] PRESCALE_FAST_LAST = PRESCALE_W'(ABD_DIV_FAST - 1);
   localparam logic [PRESCALE_W-1:0] PRESCALE_ZERO = 9'h000;
   localparam logic [PRESCALE_W-1:0] PRESCALE_ONE = 9'h001;

   // Divisor counter.
   localparam int unsigned DIV_W = 16;
   localparam logic [DIV_W-1:0] DIV_RESET = 16'h0000;
   localparam logic [DIV_W-1:0] DIV_START = 16'h0001;
   localparam logic [DIV_W-1:0] DIV_ONE = 16'h0001;
   localparam logic [DIV_W-1:0] DIV_MAX = 16'hFFFF;
   localparam int unsigned DIV_HIGH_MSB = 15;
   localparam int unsigned DIV_HIGH_LSB = 8;
   localparam int unsigned DIV_LOW_MSB = 7;
   localparam int unsigned DIV_LOW_LSB = 0;

   // Rising edges of the sync character, stop bit edge included.
   localparam logic [2:0] RISE_FIRST = 3'h1;
   localparam logic [2:0] RISE_LAST = 3'h5;
   localparam logic [2:0] RISE_ONE = 3'h1;
   localparam logic [2:0] RISE_ZERO = 3'h0;

   typedef enum logic [4:0] {
      ST_IDLE = 5'b00001,
      ST_WAKE_FALL = 5'b00010,
      ST_WAKE_RISE = 5'b00100,
      ST_ABD_START = 5'b01000,
      ST_ABD_COUNT = 5'b10000
   } state_t;

   typedef enum logic [1:0] {
      ST_ABD_SUB_START = 2'b01,
      ST_ABD_SUB_FIRST = 2'b10
   } abd_sub_t;
endpackage : abw_pkg

// ===== abw_properties.sv
`timescale 1ns/1ps
module abw_checker (
   input wire logic clk_i, // Clock.
   input wire logic rstn_i, // Reset.
   input wire logic rx_i, // Line.
   input wire logic sync_mode_i, // Sync mode.
   input wire logic autobaud_enable_set_i, // Set.
   input wire logic wake_enable_set_i, // Set.
   input wire logic overflow_clr_i, // Clear.
   input wire logic buffer_read_i, // Read.
   input wire logic autobaud_enable_o, // Enable.
   input wire logic wake_on_break_enable_o, // Enable.
   input wire logic autobaud_overflow_flag_o, // Flag.
   input wire logic receive_flag_o, // Flag.
   input wire logic receiver_hold_o, // Hold.
   input wire logic wake_event_o, // Pulse.
   input wire logic autobaud_done_o // Pulse.
);
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (!rstn_i);
   sequence s_low_watch;
      (wake_on_break_enable_o && !sync_mode_i && !rx_i)[*4];
   endsequence
   sequence s_high;
      (rx_i && !sync_mode_i && !wake_enable_set_i)[*8];
   endsequence
   property p_break_end;
      s_low_watch ##1 s_high |-> !wake_on_break_enable_o;
   endproperty
   property p_done;
      autobaud_done_o |-> receive_flag_o && !autobaud_enable_o;
   endproperty
   property p_read;
      buffer_read_i && !autobaud_enable_o && !wake_on_break_enable_o && !receiver_hold_o
         && !autobaud_enable_set_i |=> !receive_flag_o;
   endproperty
   property p_ovf_hold;
      autobaud_overflow_flag_o && autobaud_enable_o |=> autobaud_overflow_flag_o;
   endproperty
   property p_ovf_clr;
      overflow_clr_i && !autobaud_enable_o |=> !autobaud_overflow_flag_o;
   endproperty
   property p_ab_hold;
      autobaud_enable_o |=> receiver_hold_o;
   endproperty
   property p_wake_hold;
      wake_on_break_enable_o && !sync_mode_i |=> receiver_hold_o;
   endproperty
   property p_sync;
      sync_mode_i && !wake_on_break_enable_o |=> !wake_on_break_enable_o;
   endproperty
   property p_wake_evt;
      wake_event_o |-> receive_flag_o;
   endproperty
   a_break_end: assert property (p_break_end) else $error("wake enable kept");
   a_done: assert property (p_done) else $error("done without flag");
   a_read: assert property (p_read) else $error("read kept flag");
   a_ovf_hold: assert property (p_ovf_hold) else $error("overflow lost");
   a_ovf_clr: assert property (p_ovf_clr) else $error("overflow kept");
   a_ab_hold: assert property (p_ab_hold) else $error("no hold");
   a_wake_hold: assert property (p_wake_hold) else $error("no hold");
   a_sync: assert property (p_sync) else $error("wake set in sync");
   a_wake_evt: assert property (p_wake_evt) else $error("event without flag");
endmodule : abw_checker
bind autobaud_and_wake_on_break abw_checker chk_u (.clk_i, .rstn_i, .rx_i, .sync_mode_i,
   .autobaud_enable_set_i, .wake_enable_set_i, .overflow_clr_i, .buffer_read_i,
   .autobaud_enable_o, .wake_on_break_enable_o, .autobaud_overflow_flag_o, .receive_flag_o,
   .receiver_hold_o, .wake_event_o, .autobaud_done_o);

// ===== autobaud_and_wake_on_break.sv
`timescale 1ns/1ps
// Behaviour
// - Measurement holds receiver idle; edges time counter
// - Time sync character from first to fifth rise
// - Fifth rise: keep count, clear enable, flag
// - Buffer read clears receive flag
// - Divisor pair is one 16-bit counter
// - Counter ticks at one eighth base clock
// - Select bits choose divide 512, 128, 32
// - Counter starts at one
// - With wake enabled, measure following character
// - Overflow sets flag, counting continues to fifth
// - Overflow clear ignored while enable stays set
// - Wake works only in asynchronous mode
// - Wake enabled: receiver idle, watch falling edge if line high, else wait for rise
// - Wake event sets receive flag
// - Rise ending break clears wake enable
// - Non-zero character start low wakes too
module autobaud_and_wake_on_break
   import abw_pkg::*;
(
   input wire logic clk_i, // System clock, 40 MHz.
   input wire logic rstn_i, // Synchronous reset, active low.
   input wire logic rx_i, // Receive line.
   input wire logic sync_mode_i, // High selects synchronous mode.
   input wire logic wide_divisor_select_i, // Wide divisor select.
   input wire logic high_speed_select_i, // High speed select.
   input wire logic autobaud_enable_set_i, // Pulse: software sets auto-baud enable.
   input wire logic autobaud_enable_clr_i, // Pulse: software clears auto-baud enable.
   input wire logic wake_enable_set_i, // Pulse: software sets wake enable.
   input wire logic wake_enable_clr_i, // Pulse: software clears wake enable.
   input wire logic overflow_clr_i, // Pulse: software clears overflow flag.
   input wire logic buffer_read_i, // Pulse: software reads receive buffer.
   input wire logic divisor_wr_i, // Pulse: software writes divisor pair.
   input wire logic [DIV_W-1:0] divisor_wdata_i, // Divisor value written.
   output logic autobaud_enable_o, // Auto-baud enable bit.
   output logic wake_on_break_enable_o, // Wake enable bit.
   output logic autobaud_overflow_flag_o, // Counter overflow flag.
   output logic receive_flag_o, // Receive interrupt flag.
   output logic [7:0] baud_divisor_high_o, // Divisor high byte.
   output logic [7:0] baud_divisor_low_o, // Divisor low byte.
   output logic receiver_idle_flag_o, // High while no measurement is under way.
   output logic receiver_hold_o, // Holds the normal receiver idle.
   output logic wake_event_o, // Pulse: wake event seen.
   output logic autobaud_done_o // Pulse: measurement complete.
);
   state_t state_r;
   state_t state_nxt;
   abd_sub_t sub_r;
   abd_sub_t sub_nxt;
   logic autobaud_enable_r;
   logic wake_enable_r;
   logic overflow_r;
   logic receive_flag_r;
   logic [DIV_W-1:0] divisor_r;
   logic [2:0] rise_cnt_r;
   logic idle_r;
   logic hold_r;
   logic wake_event_r;
   logic done_r;
   logic wake_event;
   logic wake_end;
   logic abd_first;
   logic abd_done;
   logic counting;
   logic overflow_hit;
   logic wake_allowed;

   rx_front_if fe ();

   rx_front u_rx_front (
      .clk_i(clk_i),
      .rstn_i(rstn_i),
      .rx_i(rx_i),
      .wide_divisor_select_i(wide_divisor_select_i),
      .high_speed_select_i(high_speed_select_i),
      .run_i(counting),
      .fe(fe)
   );

   assign wake_allowed = wake_enable_r && !sync_mode_i;
   // Counting stops in the cycle the enable drops, so an abort never adds a tick.
   assign counting = (state_r == ST_ABD_COUNT) && autobaud_enable_r;

   // Wake handling takes precedence, so a measurement armed with wake waits for the break.
   always_comb begin
      state_nxt = state_r;
      sub_nxt = sub_r;
      wake_event = 1'b0;
      wake_end = 1'b0;
      abd_first = 1'b0;
      abd_done = 1'b0;
      case (state_r)
         ST_IDLE: begin
            if (wake_allowed) begin
               state_nxt = fe.rx_level ? ST_WAKE_FALL : ST_WAKE_RISE;
            end else if (autobaud_enable_r) begin
               state_nxt = ST_ABD_START;
               sub_nxt = ST_ABD_SUB_START;
            end
         end
         // The line is high: the next falling edge is the wake event.
         ST_WAKE_FALL: begin
            if (!wake_allowed) begin
               state_nxt = ST_IDLE;
            end else if (fe.rx_fall) begin
               wake_event = 1'b1;
               state_nxt = ST_WAKE_RISE;
            end
         end
         // The line is low: the rise that ends the break releases the wake function.
         ST_WAKE_RISE: begin
            if (!wake_allowed) begin
               state_nxt = ST_IDLE;
            end else if (fe.rx_rise) begin
               wake_end = 1'b1;
               state_nxt = ST_IDLE;
            end
         end
         // A rise only counts as the first one after a start bit has been seen.
         ST_ABD_START: begin
            if (!autobaud_enable_r || wake_allowed) begin
               state_nxt = ST_IDLE;
            end else begin
               case (sub_r)
                  ST_ABD_SUB_START: begin
                     if (fe.rx_fall) begin
                        sub_nxt = ST_ABD_SUB_FIRST;
                     end
                  end
                  ST_ABD_SUB_FIRST: begin
                     if (fe.rx_rise) begin
                        abd_first = 1'b1;
                        state_nxt = ST_ABD_COUNT;
                     end
                  end
                  default: begin
                     sub_nxt = ST_ABD_SUB_START;
                  end
               endcase
            end
         end
         ST_ABD_COUNT: begin
            if (!autobaud_enable_r) begin
               state_nxt = ST_IDLE;
            end else if (fe.rx_rise && rise_cnt_r == RISE_LAST - RISE_ONE) begin
               abd_done = 1'b1;
               state_nxt = ST_IDLE;
            end
         end
         default: begin
            state_nxt = ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk_i) begin
      if (!rstn_i) begin
         state_r <= ST_IDLE;
         sub_r <= ST_ABD_SUB_START;
      end else begin
         state_r <= state_nxt;
         sub_r <= sub_nxt;
      end
   end

   // The first rise loads one, so the fifth rise is met while the count holds four.
   always_ff @(posedge clk_i) begin
      if (!rstn_i) begin
         rise_cnt_r <= RISE_ZERO;
      end else if (abd_first) begin
         rise_cnt_r <= RISE_FIRST;
      end else if (counting && fe.rx_rise) begin
         rise_cnt_r <= rise_cnt_r + RISE_ONE;
      end
   end

   // The wrap from all ones back to zero is the overflow event.
   assign overflow_hit = counting && fe.tick && (divisor_r == DIV_MAX);

   // The pair counts as one 16-bit value regardless of the wide select.
   always_ff @(posedge clk_i) begin
      if (!rstn_i) begin
         divisor_r <= DIV_RESET;
      end else if (abd_first) begin
         divisor_r <= DIV_START;
      end else if (counting && fe.tick) begin
         divisor_r <= divisor_r + DIV_ONE;
      end else if (divisor_wr_i && !counting) begin
         divisor_r <= divisor_wdata_i;
      end
   end

   // Hardware clear on completion yields to a software set in the same cycle.
   always_ff @(posedge clk_i) begin
      if (!rstn_i) begin
         autobaud_enable_r <= 1'b0;
      end else if (autobaud_enable_set_i) begin
         autobaud_enable_r <= 1'b1;
      end else if (autobaud_enable_clr_i || abd_done) begin
         autobaud_enable_r <= 1'b0;
      end
   end

   // Synchronous mode refuses the set; a bit set earlier stays but is treated as off.
   always_ff @(posedge clk_i) begin
      if (!rstn_i) begin
         wake_enable_r <= 1'b0;
      end else if (wake_enable_set_i && !sync_mode_i) begin
         wake_enable_r <= 1'b1;
      end else if (wake_enable_clr_i || wake_end) begin
         wake_enable_r <= 1'b0;
      end
   end

   // A software clear only takes effect once the enable is low.
   always_ff @(posedge clk_i) begin
      if (!rstn_i) begin
         overflow_r <= 1'b0;
      end else if (overflow_hit) begin
         overflow_r <= 1'b1;
      end else if (overflow_clr_i && !autobaud_enable_r) begin
         overflow_r <= 1'b0;
      end
   end

   always_ff @(posedge clk_i) begin
      if (!rstn_i) begin
         receive_flag_r <= 1'b0;
      end else if (abd_done || wake_event) begin
         receive_flag_r <= 1'b1;
      end else if (buffer_read_i) begin
         receive_flag_r <= 1'b0;
      end
   end

   // The normal receiver is held while either function owns the line.
   always_ff @(posedge clk_i) begin
      if (!rstn_i) begin
         hold_r <= 1'b0;
      end else begin
         hold_r <= autobaud_enable_r || wake_allowed;
      end
   end

   // Idle drops once the start bit is seen and returns after the fifth rise.
   always_ff @(posedge clk_i) begin
      if (!rstn_i) begin
         idle_r <= 1'b1;
      end else begin
         idle_r <= !(counting || (state_r == ST_ABD_START && sub_r == ST_ABD_SUB_FIRST));
      end
   end

   // The event pulses rise on the same edge that sets the receive flag.
   always_ff @(posedge clk_i) begin
      if (!rstn_i) begin
         wake_event_r <= 1'b0;
      end else begin
         wake_event_r <= wake_event;
      end
   end

   always_ff @(posedge clk_i) begin
      if (!rstn_i) begin
         done_r <= 1'b0;
      end else begin
         done_r <= abd_done;
      end
   end

   assign autobaud_enable_o = autobaud_enable_r;
   assign wake_on_break_enable_o = wake_enable_r;
   assign autobaud_overflow_flag_o = overflow_r;
   assign receive_flag_o = receive_flag_r;
   assign baud_divisor_high_o = divisor_r[DIV_HIGH_MSB:DIV_HIGH_LSB];
   assign baud_divisor_low_o = divisor_r[DIV_LOW_MSB:DIV_LOW_LSB];
   assign receiver_idle_flag_o = idle_r;
   assign receiver_hold_o = hold_r;
   assign wake_event_o = wake_event_r;
   assign autobaud_done_o = done_r;
endmodule : autobaud_and_wake_on_break

// ===== autobaud_and_wake_on_break_test.sv
`timescale 1ns/1ps
module autobaud_and_wake_on_break_test;
   import abw_pkg::*;
   logic clk_i = 1'b0;
   logic rstn_i = 1'b0;
   logic rx_w;
   logic sync_mode_i = 1'b0;
   logic [1:0] sel = 2'b00;
   logic [5:0] pl = 6'h00;
   logic wr = 1'b0;
   logic [15:0] wd = 16'h0000;
   logic ae, we, ovf, rf, idle, hold, wev, done;
   logic [7:0] dh, dl;
   int mismatches = 0;
   int checks_done = 0;
   int cycles = 0;
   int seed_v;
   always #12.5 clk_i = ~clk_i;
   lin_sender tx_u (.clk_i(clk_i), .rx_o(rx_w));
   autobaud_and_wake_on_break dut_u (.clk_i(clk_i), .rstn_i(rstn_i), .rx_i(rx_w),
      .sync_mode_i(sync_mode_i), .wide_divisor_select_i(sel[1]), .high_speed_select_i(sel[0]),
      .autobaud_enable_set_i(pl[5]), .autobaud_enable_clr_i(pl[4]), .wake_enable_set_i(pl[3]),
      .wake_enable_clr_i(pl[2]), .overflow_clr_i(pl[1]), .buffer_read_i(pl[0]),
      .divisor_wr_i(wr), .divisor_wdata_i(wd), .autobaud_enable_o(ae),
      .wake_on_break_enable_o(we), .autobaud_overflow_flag_o(ovf), .receive_flag_o(rf),
      .baud_divisor_high_o(dh), .baud_divisor_low_o(dl), .receiver_idle_flag_o(idle),
      .receiver_hold_o(hold), .wake_event_o(wev), .autobaud_done_o(done));
   task automatic final_report;
      $display("checks_done=%0d mismatches=%0d", checks_done, mismatches);
      if (mismatches == 0 && checks_done > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask : final_report
   always @(posedge clk_i) begin
      cycles++;
      if (cycles == 100000) begin
         mismatches++;
         final_report();
      end
   end
   task automatic check(input logic c, input string m);
      checks_done++;
      if (c !== 1'b1) begin
         mismatches++;
         $display("mismatch at %0t: %s", $time, m);
      end
   endtask : check
   task automatic pulse(input logic [5:0] p);
      @(negedge clk_i);
      pl = p;
      @(negedge clk_i);
      pl = 6'h00;
      repeat (3) @(negedge clk_i);
   endtask : pulse
   function automatic int div_of(input logic [1:0] s);
      return (s == 2'b00) ? ABD_DIV_SLOW : (s == 2'b11) ? ABD_DIV_FAST : ABD_DIV_MID;
   endfunction : div_of
   // Keeps the last tick well away from the fifth rise so the count is exact.
   function automatic int pick_bit(input int d);
      int b;
      b = 40 + ($urandom % 160);
      while ((8 * b) % d < d / 4 || (8 * b) % d > 3 * d / 4) begin
         b++;
      end
      return b;
   endfunction : pick_bit
   task automatic wait_done;
      int n;
      n = 0;
      while (done !== 1'b1 && n < 60000) begin
         @(negedge clk_i);
         n++;
      end
      check(n < 60000, "no completion");
   endtask : wait_done
   task automatic ab_run(input logic [1:0] s, input int b);
      logic [15:0] exp_v;
      exp_v = 16'(1 + (8 * b) / div_of(s));
      sel = s;
      pulse(6'h20);
      check(ae === 1'b1 && hold === 1'b1, "enable");
      fork
         tx_u.send_char(8'h55, b);
         wait_done();
      join
      check({dh, dl} === exp_v, "count");
      check(s[1] || ((dh === 8'h00) === (exp_v < 16'h0100)), "high byte");
      check(ae === 1'b0 && rf === 1'b1, "completion");
      pulse(6'h01);
      check(rf === 1'b0, "flag read");
   endtask : ab_run
   initial begin
      seed_v = $urandom(96);
      repeat (10) @(negedge clk_i);
      rstn_i = 1'b1;
      repeat (3) @(negedge clk_i);
      check({ae, we, ovf, rf, dh, dl} === 20'h00000 && idle === 1'b1, "reset");
      wd = 16'($urandom);
      wr = 1'b1;
      @(negedge clk_i);
      wr = 1'b0;
      @(negedge clk_i);
      check({dh, dl} === wd, "divisor write");
      for (int i = 0; i < 8; i++) begin
         ab_run(2'(i), pick_bit(div_of(2'(i))));
      end
      ab_run(2'b01, 4200);
      check(idle === 1'b1, "idle before wake");
      pulse(6'h08);
      check(hold === 1'b1, "wake hold");
      tx_u.send_break(13, 20);
      check(rf === 1'b1 && we === 1'b0, "wake");
      pulse(6'h01);
      pulse(6'h28);
      tx_u.send_break(13, 20);
      check(ae === 1'b1 && rf === 1'b1 && we === 1'b0, "break skipped");
      pulse(6'h01);
      fork
         tx_u.send_char(8'h55, 24);
         wait_done();
      join
      check({dh, dl} === 16'(1 + (8 * 24) / div_of(sel)), "count after break");
      pulse(6'h01);
      pulse(6'h08);
      tx_u.send_char(8'hF0, 20);
      check(rf === 1'b1 && we === 1'b0, "char wake");
      pulse(6'h01);
      sync_mode_i = 1'b1;
      pulse(6'h08);
      check(we === 1'b0, "sync refuse");
      sync_mode_i = 1'b0;
      pulse(6'h20);
      fork
         tx_u.send_char(8'h55, 60);
         begin
            repeat (200) @(negedge clk_i);
            pulse(6'h10);
            pulse(6'h02);
         end
      join
      check(ae === 1'b0 && rf === 1'b0 && ovf === 1'b0, "abort");
      final_report();
   end
endmodule : autobaud_and_wake_on_break_test

// ===== lin_sender.sv
`timescale 1ns/1ps
module lin_sender (
   input wire logic clk_i, // Bit timing base.
   output logic rx_o // Line, idles high.
);
   initial rx_o = 1'b1;
   task automatic hold_bits(input logic v, input int n, input int b);
      rx_o = v;
      repeat (n * b) @(negedge clk_i);
   endtask : hold_bits
   task automatic send_char(input logic [7:0] d, input int b);
      hold_bits(1'b0, 1, b);
      for (int i = 0; i < 8; i++) begin
         hold_bits(d[i], 1, b);
      end
      hold_bits(1'b1, 2, b);
   endtask : send_char
   // The idle tail gives the receiver time to settle before the next character.
   task automatic send_break(input int n, input int b);
      hold_bits(1'b0, n, b);
      hold_bits(1'b1, 4, b);
   endtask : send_break
endmodule : lin_sender

// ===== rx_front.sv
`timescale 1ns/1ps
module rx_front
   import abw_pkg::*;
(
   input wire logic clk_i, // System clock.
   input wire logic rstn_i, // Synchronous reset, active low.
   input wire logic rx_i, // Receive line.
   input wire logic wide_divisor_select_i, // Wide divisor select.
   input wire logic high_speed_select_i, // High speed select.
   input wire logic run_i, // Runs the measurement prescaler.
   rx_front_if.src fe // Synchronised line, edges and tick.
);
   logic sync1_r;
   logic sync2_r;
   logic sync3_r;
   logic [PRESCALE_W-1:0] pre_r;
   logic [PRESCALE_W-1:0] pre_last;

   // The line idles high, so the synchroniser resets to one.
   always_ff @(posedge clk_i) begin
      if (!rstn_i) begin
         sync1_r <= 1'b1;
         sync2_r <= 1'b1;
         sync3_r <= 1'b1;
      end else begin
         sync1_r <= rx_i;
         sync2_r <= sync1_r;
         sync3_r <= sync2_r;
      end
   end

   assign fe.rx_level = sync2_r;
   assign fe.rx_rise = sync2_r & ~sync3_r;
   assign fe.rx_fall = ~sync2_r & sync3_r;

   always_comb begin
      case ({wide_divisor_select_i, high_speed_select_i})
         2'b00: pre_last = PRESCALE_SLOW_LAST;
         2'b11: pre_last = PRESCALE_FAST_LAST;
         default: pre_last = PRESCALE_MID_LAST;
      endcase
   end

   always_ff @(posedge clk_i) begin
      if (!rstn_i || !run_i) begin
         pre_r <= PRESCALE_ZERO;
      end else if (pre_r >= pre_last) begin
         pre_r <= PRESCALE_ZERO;
      end else begin
         pre_r <= pre_r + PRESCALE_ONE;
      end
   end

   assign fe.tick = run_i && (pre_r >= pre_last);
endmodule : rx_front

// ===== rx_front_if.sv
`timescale 1ns/1ps
interface rx_front_if;
   logic rx_level;
   logic rx_rise;
   logic rx_fall;
   logic tick;
   modport src (output rx_level, output rx_rise, output rx_fall, output tick);
   modport snk (input rx_level, input rx_rise, input rx_fall, input tick);
endinterface : rx_front_if
